/* File: core/input_cal.sv */
/*
 * Front-panel two-point calibration of the input conversion of a rate meter.
 * Assumes buttons arrive unsynchronised and debounced; the input value comes
 * from logic on the same clock.
 */
// Operation
// - Reading is (input plus offset) times scale.
// - Scale is slope, offset from line.
// - Calibration parameter reachable only in rate mode.
// - Menu cycles parameters; advance opens prompt, entry.
// - Entry flashes digit; increment digit, advance moves.
// - Menu shows target prompt; next menu saves point.
// - Final menu computes, shows output parameter.
// - Unacceptable calibration shows an error message.
`timescale 1ns/1ns
module input_cal
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Front panel and mode
    input wire cal_pkg::buttons_t buttons_i,
    input wire logic rate_mode_i,
    // Measured rate
    input wire logic [cal_pkg::VAL_W-1:0] input_value_i,
    // Display
    output cal_pkg::disp_t disp_item_o,
    output logic [2:0] param_idx_o,
    output logic [cal_pkg::BCD_W-1:0] entry_digits_o,
    output logic [2:0] flash_pos_o,
    output logic signed [cal_pkg::OUT_W-1:0] reading_o,
    // Calibration state
    output cal_pkg::cal_t cal_o,
    output logic cal_err_o
);
    import cal_pkg::*;

    typedef enum logic [3:0] {
        S_PARAM, S_IN1, S_E_IN1, S_RD1, S_E_RD1, S_IN2, S_E_IN2,
        S_RD2, S_E_RD2, S_DIV_SC, S_DIV_OF, S_ERR
    } state_t;

    function automatic logic [VAL_W-1:0] bcd_to_bin(
        input logic [BCD_W-1:0] b);
        logic [VAL_W+3:0] acc;
        acc = '0;
        for (int i = DIGITS - 1; i >= 0; i--)
        begin
            acc = (VAL_W+4)'(acc * 10) + (VAL_W+4)'(b[4*i +: 4]);
        end
        return acc[VAL_W-1:0];
    endfunction : bcd_to_bin

    // Button synchronisers and press detection
    logic [2:0] sync1_reg, sync2_reg, sync3_reg;
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            sync3_reg <= 3'h0;
        end
        else
        begin
            sync1_reg <= {buttons_i.menu, buttons_i.adv, buttons_i.inc};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end
    logic [2:0] press;
    assign press = sync2_reg & ~sync3_reg;
    logic p_menu, p_adv, p_inc;
    assign p_menu = press[2];
    assign p_adv = press[1];
    assign p_inc = press[0];

    state_t st_reg, st_next;
    logic [2:0] idx_reg, idx_next, pos_reg, pos_next;
    logic [BCD_W-1:0] dig_reg, dig_next;
    logic [VAL_W-1:0] in1_reg, in1_next, rd1_reg, rd1_next;
    logic [VAL_W-1:0] in2_reg, in2_next, rd2_reg, rd2_next;
    cal_t cal_reg, cal_next;
    logic err_reg, err_next;
    logic [DIV_W-1:0] quo_reg, quo_next;
    logic [DIVR_W-1:0] rem_reg, rem_next, dvs_reg, dvs_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic neg_reg, neg_next;
    logic signed [SCALE_W-1:0] scale_tmp_reg, scale_tmp_next;
    disp_t disp_reg, disp_next;

    logic signed [VAL_W:0] d_in, d_rd;
    logic [VAL_W:0] m_in, m_rd;
    logic [DIVR_W:0] trial;
    assign d_in = $signed({1'b0, in2_reg}) - $signed({1'b0, in1_reg});
    assign d_rd = $signed({1'b0, rd2_reg}) - $signed({1'b0, rd1_reg});
    assign m_in = d_in[VAL_W] ? (VAL_W+1)'(-d_in) : d_in;
    assign m_rd = d_rd[VAL_W] ? (VAL_W+1)'(-d_rd) : d_rd;
    assign trial = {rem_reg, quo_reg[DIV_W-1]} - {1'b0, dvs_reg};

    always_comb
    begin
        st_next = st_reg;
        idx_next = idx_reg;
        pos_next = pos_reg;
        dig_next = dig_reg;
        in1_next = in1_reg;
        rd1_next = rd1_reg;
        in2_next = in2_reg;
        rd2_next = rd2_reg;
        cal_next = cal_reg;
        err_next = err_reg;
        quo_next = quo_reg;
        rem_next = rem_reg;
        dvs_next = dvs_reg;
        cnt_next = cnt_reg;
        neg_next = neg_reg;
        scale_tmp_next = scale_tmp_reg;
        case (st_reg)
            S_PARAM:
            begin
                // menu steps, calibration skipped outside rate mode
                if (p_menu)
                begin
                    idx_next = (idx_reg == N_PARAMS - 3'h1) ? 3'h0
                             : idx_reg + 3'h1;
                    if (idx_next == PARAM_ISO && !rate_mode_i)
                    begin
                        idx_next = idx_next + 3'h1;
                    end
                end
                else if (p_adv && idx_reg == PARAM_ISO && rate_mode_i)
                begin
                    st_next = S_IN1;
                end
            end
            S_IN1, S_RD1, S_IN2, S_RD2:
            begin
                // advance on a prompt opens entry from zero
                if (p_adv)
                begin
                    st_next = state_t'(st_reg + 4'h1);
                    dig_next = '0;
                    pos_next = POS_FIRST;
                end
            end
            S_E_IN1, S_E_RD1, S_E_IN2, S_E_RD2:
            begin
                if (p_inc)
                begin
                    dig_next[4*pos_reg +: 4] = (dig_reg[4*pos_reg +: 4] == 4'h9)
                        ? 4'h0 : dig_reg[4*pos_reg +: 4] + 4'h1;
                end
                else if (p_adv)
                begin
                    pos_next = (pos_reg == 3'h0) ? POS_FIRST : pos_reg - 3'h1;
                end
                else if (p_menu)
                begin
                    // menu stores the entry and moves to next prompt, or to the slope division after rd2
                    case (st_reg)
                        S_E_IN1: in1_next = bcd_to_bin(dig_reg);
                        S_E_RD1: rd1_next = bcd_to_bin(dig_reg);
                        S_E_IN2: in2_next = bcd_to_bin(dig_reg);
                        default: rd2_next = bcd_to_bin(dig_reg);
                    endcase
                    st_next = state_t'(st_reg + 4'h1);
                end
            end
            S_DIV_SC:
            begin
                if (cnt_reg == '0)
                begin
                    // equal inputs (or equal targets) cannot calibrate
                    if (m_in == '0 || m_rd == '0)
                    begin
                        err_next = 1'b1;
                        st_next = S_ERR;
                    end
                    else
                    begin
                        // slope = d_rd / d_in in fixed point
                        quo_next = DIV_W'({m_rd, {FRAC_W{1'b0}}});
                        dvs_next = m_in;
                        rem_next = '0;
                        neg_next = d_rd[VAL_W] ^ d_in[VAL_W];
                        cnt_next = DIV_STEPS;
                    end
                end
                else
                begin
                    rem_next = trial[DIVR_W] ? {rem_reg[DIVR_W-2:0],
                        quo_reg[DIV_W-1]} : trial[DIVR_W-1:0];
                    quo_next = {quo_reg[DIV_W-2:0], ~trial[DIVR_W]};
                    cnt_next = cnt_reg - 6'h1;
                    if (cnt_reg == 6'h1)
                    begin
                        scale_tmp_next = neg_reg
                            ? -$signed(quo_next[SCALE_W-1:0])
                            : $signed(quo_next[SCALE_W-1:0]);
                        // offset = rd1 * d_in / d_rd - in1
                        quo_next = DIV_W'(rd1_reg) * DIV_W'(m_in);
                        dvs_next = m_rd;
                        rem_next = '0;
                        cnt_next = DIV_STEPS;
                        st_next = S_DIV_OF;
                    end
                end
            end
            S_DIV_OF:
            begin
                rem_next = trial[DIVR_W] ? {rem_reg[DIVR_W-2:0],
                    quo_reg[DIV_W-1]} : trial[DIVR_W-1:0];
                quo_next = {quo_reg[DIV_W-2:0], ~trial[DIVR_W]};
                cnt_next = cnt_reg - 6'h1;
                if (cnt_reg == 6'h1)
                begin
                    // commit and show the output parameter
                    cal_next.scale = scale_tmp_reg;
                    cal_next.offset = (neg_reg
                        ? -$signed({1'b0, quo_next[VAL_W-1:0]})
                        : $signed({1'b0, quo_next[VAL_W-1:0]}))
                        - $signed({1'b0, in1_reg});
                    err_next = 1'b0;
                    idx_next = PARAM_OSO;
                    st_next = S_PARAM;
                end
            end
            S_ERR:
            begin
                if (p_menu)
                begin
                    idx_next = PARAM_OSO;
                    st_next = S_PARAM;
                end
            end
            default: st_next = S_PARAM;
        endcase
        // display item follows the next state
        case (st_next)
            S_PARAM: disp_next = D_PARAM;
            S_IN1: disp_next = D_IN1;
            S_RD1: disp_next = D_RD1;
            S_IN2: disp_next = D_IN2;
            S_RD2: disp_next = D_RD2;
            S_DIV_SC, S_DIV_OF: disp_next = D_BUSY;
            S_ERR: disp_next = D_ERR;
            default: disp_next = D_ENTRY;
        endcase
    end

    logic signed [VAL_W+1:0] sum;
    logic signed [VAL_W+SCALE_W+1:0] prod;
    logic signed [OUT_W-1:0] read_next, read_reg;
    assign sum = $signed({2'b00, input_value_i}) + cal_reg.offset;
    assign prod = sum * cal_reg.scale;
    assign read_next = OUT_W'(prod >>> FRAC_W);

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st_reg <= S_PARAM;
            idx_reg <= PARAM_RESET;
            pos_reg <= POS_FIRST;
            dig_reg <= '0;
            in1_reg <= '0;
            rd1_reg <= '0;
            in2_reg <= '0;
            rd2_reg <= '0;
            cal_reg <= '{scale: SCALE_RESET, offset: OFFSET_RESET};
            err_reg <= 1'b0;
            quo_reg <= '0;
            rem_reg <= '0;
            dvs_reg <= '0;
            cnt_reg <= '0;
            neg_reg <= 1'b0;
            scale_tmp_reg <= '0;
            disp_reg <= D_PARAM;
            read_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
            idx_reg <= idx_next;
            pos_reg <= pos_next;
            dig_reg <= dig_next;
            in1_reg <= in1_next;
            rd1_reg <= rd1_next;
            in2_reg <= in2_next;
            rd2_reg <= rd2_next;
            cal_reg <= cal_next;
            err_reg <= err_next;
            quo_reg <= quo_next;
            rem_reg <= rem_next;
            dvs_reg <= dvs_next;
            cnt_reg <= cnt_next;
            neg_reg <= neg_next;
            scale_tmp_reg <= scale_tmp_next;
            disp_reg <= disp_next;
            read_reg <= read_next;
        end
    end

    assign disp_item_o = disp_reg;
    assign param_idx_o = idx_reg;
    assign entry_digits_o = dig_reg;
    assign flash_pos_o = pos_reg;
    assign reading_o = read_reg;
    assign cal_o = cal_reg;
    assign cal_err_o = err_reg;

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    sequence menu_in_entry;
        p_menu && !p_adv && !p_inc && (st_reg == S_E_RD1);
    endsequence
    sequence last_menu;
        p_menu && !p_adv && !p_inc && (st_reg == S_E_RD2);
    endsequence

    a_reading_conv: assert property (
        (cal_reg.scale == SCALE_RESET && cal_reg.offset == OFFSET_RESET)
            |=> read_reg == OUT_W'($past(input_value_i)))
        else $error("reading not converted from input");
    a_iso_mode_gate: assert property (
        (st_reg == S_PARAM && !rate_mode_i) |=> st_reg == S_PARAM)
        else $error("calibration entered outside rate mode");
    a_prompt_opens: assert property (
        (st_reg == S_IN1 && p_adv) |=> st_reg == S_E_IN1 && dig_reg == '0)
        else $error("advance did not open entry");
    a_digit_inc: assert property (
        (st_reg == S_E_IN1 && p_inc && pos_reg == 3'h2)
            |=> dig_reg[11:8] == (($past(dig_reg[11:8]) == 4'h9) ? 4'h0
            : $past(dig_reg[11:8]) + 4'h1))
        else $error("digit not incremented");
    a_point_saved: assert property (
        menu_in_entry |=> st_reg == S_IN2 && disp_reg == D_IN2
            && rd1_reg == bcd_to_bin($past(dig_reg)))
        else $error("low point not saved");
    a_cal_done: assert property (
        (last_menu ##1 !(m_in == '0 || m_rd == '0))
            |-> ##[80:84] (st_reg == S_PARAM && idx_reg == PARAM_OSO))
        else $error("calibration did not complete");
    a_err_shown: assert property (
        (last_menu ##1 (m_in == '0)) |=> disp_reg == D_ERR && err_reg)
        else $error("error not shown");
    a_err_keeps_cal: assert property (
        (st_reg == S_DIV_SC && cnt_reg == '0 && m_in == '0)
            |=> $stable(cal_reg))
        else $error("calibration changed on equal inputs");
endmodule : input_cal

/* File: core/cal_pkg.sv */
/*
 * Shared types and constants of the two-point input calibration block.
 * Assumes one system clock of 25 MHz and an active-low asynchronous reset.
 */
package cal_pkg;
    localparam int VAL_W = 20;
    localparam int DIGITS = 6;
    localparam int BCD_W = 4 * DIGITS;
    localparam int SCALE_W = 32;
    localparam int FRAC_W = 16;
    localparam int OUT_W = 32;
    localparam int DIV_W = 40;
    localparam int DIVR_W = 21;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] DIV_STEPS = 6'd40;
    localparam logic [2:0] N_PARAMS = 3'd7;
    localparam logic [2:0] PARAM_RESET = 3'h0;
    localparam logic [2:0] PARAM_ISO = 3'h5;
    localparam logic [2:0] PARAM_OSO = 3'h6;
    localparam logic [2:0] POS_FIRST = 3'h5;
    localparam logic [SCALE_W-1:0] SCALE_RESET = 32'h0001_0000;
    localparam logic [VAL_W:0] OFFSET_RESET = 21'h0;

    typedef struct packed {
        logic menu;
        logic adv;
        logic inc;
    } buttons_t;

    typedef struct packed {
        logic signed [SCALE_W-1:0] scale;
        logic signed [VAL_W:0] offset;
    } cal_t;

    typedef enum logic [2:0] {
        D_PARAM,
        D_IN1,
        D_RD1,
        D_IN2,
        D_RD2,
        D_ENTRY,
        D_BUSY,
        D_ERR
    } disp_t;
endpackage : cal_pkg

/* File: tb/panel_model.sv */
/*
 * Front-panel model: a person pressing the menu, advance and increment
 * buttons of the calibration block.
 * Assumes the block synchronises and edge-detects the raw levels.
 */
`timescale 1ns/1ns
module panel_model
(
    // Clock
    input wire logic clk_sys_i,
    // Buttons to the block
    output cal_pkg::buttons_t buttons_o
);
    import cal_pkg::*;

    initial
    begin
        buttons_o = '0;
    end

    task automatic press(input int which, input int hold);
        @(negedge clk_sys_i);
        buttons_o[which] = 1'b1;
        repeat (hold) @(negedge clk_sys_i);
        buttons_o = '0;
        repeat (hold) @(negedge clk_sys_i);
    endtask : press
endmodule : panel_model

/* File: tb/test_input_cal.sv */
/*
 * Self-checking bench of the two-point input calibration block.
 * Assumes the panel model drives the buttons; one 25 MHz clock.
 */
`timescale 1ns/1ns
module test_input_cal;
    import cal_pkg::*;
    localparam int B_MENU = 2;
    localparam int B_ADV = 1;
    localparam int B_INC = 0;
    logic clk_sys_i = 1'b0;
    logic arst_n_i;
    logic rate_mode_i;
    logic [VAL_W-1:0] input_value_i;
    buttons_t buttons;
    disp_t disp_item_o;
    logic [2:0] param_idx_o;
    logic [BCD_W-1:0] entry_digits_o;
    logic [2:0] flash_pos_o;
    logic signed [OUT_W-1:0] reading_o;
    cal_t cal_o;
    logic cal_err_o;
    int failures = 0;
    int compares = 0;
    int cycles = 0;

    always #20 clk_sys_i = ~clk_sys_i;

    panel_model pnl (.clk_sys_i(clk_sys_i), .buttons_o(buttons));

    input_cal dut (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .buttons_i(buttons),
        .rate_mode_i(rate_mode_i), .input_value_i(input_value_i),
        .disp_item_o(disp_item_o), .param_idx_o(param_idx_o),
        .entry_digits_o(entry_digits_o), .flash_pos_o(flash_pos_o),
        .reading_o(reading_o), .cal_o(cal_o), .cal_err_o(cal_err_o)
    );

    task automatic stop_test;
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_reading(input logic [19:0] inp, input logic [31:0] exp);
        input_value_i = inp;
        repeat (3) @(negedge clk_sys_i);
        chk(reading_o, exp);
    endtask : chk_reading

    task automatic enter(input logic [23:0] bcd);
        for (int i = 5; i >= 0; i--)
        begin
            repeat (bcd[4*i+:4]) pnl.press(B_INC, 4);
            pnl.press(B_ADV, 4);
            chk(32'(flash_pos_o), (i == 0) ? 32'h5 : 32'(i - 1));
        end
        chk({8'h00, entry_digits_o}, {8'h00, bcd});
    endtask : enter

    task automatic run_cal(input logic [23:0] in1, input logic [23:0] rd1,
        input logic [23:0] in2, input logic [23:0] rd2);
        for (int n = 0; n < 8 && param_idx_o !== PARAM_ISO; n++)
            pnl.press(B_MENU, 4);
        chk(32'(param_idx_o), 32'(PARAM_ISO));
        pnl.press(B_ADV, 4);
        chk(32'(disp_item_o), 32'(D_IN1));
        pnl.press(B_ADV, 4);
        chk(32'(disp_item_o), 32'(D_ENTRY));
        enter(in1);
        pnl.press(B_MENU, 4);
        chk(32'(disp_item_o), 32'(D_RD1));
        pnl.press(B_ADV, 4);
        enter(rd1);
        pnl.press(B_MENU, 4);
        chk(32'(disp_item_o), 32'(D_IN2));
        pnl.press(B_ADV, 4);
        enter(in2);
        pnl.press(B_MENU, 4);
        chk(32'(disp_item_o), 32'(D_RD2));
        pnl.press(B_ADV, 4);
        enter(rd2);
        pnl.press(B_MENU, 4);
        for (int n = 0; n < 300 && disp_item_o === D_BUSY; n++)
            @(negedge clk_sys_i);
    endtask : run_cal

    task automatic t_reset_values;
        chk(32'(disp_item_o), 32'(D_PARAM));
        chk(32'(flash_pos_o), 32'h5);
        chk(cal_o.scale, 32'h0001_0000);
        chk({11'h000, cal_o.offset}, 32'h0000_0000);
        chk_reading(20'h00064, 32'h0000_0064);
    endtask : t_reset_values

    task automatic t_menu_skip;
        rate_mode_i = 1'b0;
        repeat (4) pnl.press(B_MENU, 10);
        chk(32'(param_idx_o), 32'h4);
        pnl.press(B_MENU, 4);
        chk(32'(param_idx_o), 32'(PARAM_OSO));
        pnl.press(B_ADV, 4);
        chk(32'(disp_item_o), 32'(D_PARAM));
        pnl.press(B_MENU, 4);
        chk(32'(param_idx_o), 32'h0);
        rate_mode_i = 1'b1;
    endtask : t_menu_skip

    task automatic t_good_cal;
        run_cal(24'h000100, 24'h000000, 24'h001100, 24'h002000);
        chk(32'(disp_item_o), 32'(D_PARAM));
        chk(32'(param_idx_o), 32'(PARAM_OSO));
        chk(cal_o.scale, 32'h0002_0000);
        chk({11'h000, cal_o.offset}, 32'h001F_FF9C);
        chk(32'(cal_err_o), 32'h0);
        chk_reading(20'h00258, 32'h0000_03E8);
    endtask : t_good_cal

    task automatic t_equal_inputs;
        run_cal(24'h000500, 24'h000010, 24'h000500, 24'h000900);
        chk(32'(disp_item_o), 32'(D_ERR));
        chk(32'(cal_err_o), 32'h1);
        chk(cal_o.scale, 32'h0002_0000);
        chk({11'h000, cal_o.offset}, 32'h001F_FF9C);
        pnl.press(B_MENU, 4);
        chk(32'(param_idx_o), 32'(PARAM_OSO));
        chk_reading(20'h00258, 32'h0000_03E8);
        // Equal targets give no usable slope either
        run_cal(24'h000100, 24'h000300, 24'h000200, 24'h000300);
        chk(32'(disp_item_o), 32'(D_ERR));
        chk(cal_o.scale, 32'h0002_0000);
        pnl.press(B_MENU, 4);
        chk(32'(param_idx_o), 32'(PARAM_OSO));
    endtask : t_equal_inputs

    // Hang guard, well above the expected run length
    always @(negedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            failures++;
            stop_test();
        end
    end

    initial
    begin
        arst_n_i = 1'b0;
        rate_mode_i = 1'b1;
        input_value_i = 20'h00000;
        repeat (20) @(negedge clk_sys_i);
        arst_n_i = 1'b1;
        @(negedge clk_sys_i);
        t_reset_values();
        t_menu_skip();
        t_good_cal();
        t_equal_inputs();
        stop_test();
    end
endmodule : test_input_cal
